// ---- hdl/tzr_readout_regs.sv ----
// Purpose: Register side of a two-zone thermal monitor with fan control feed
// Assumes: A serial interface engine turns bus traffic into byte accesses
// Notes:   Read data appears the cycle after reg_rd; unmapped reads give 00h
// Overview of operation
// - Reserved bits of every register read as zero regardless of writes.
// - Each zone reading is a signed 10-bit two's complement Celsius value.
// - The remote zone reading carries the external diode result.
// - The local zone reading carries the on-die sensor result.
// - An absent or faulty remote diode gives the reading code 8000h.
// - The fault code sets the remote zone limit flag and the diode fault flag.
// - Reading registers are read-only and writes to them change nothing.
// - Every measurement is compared to the limits and sets an alarm flag if exceeded.
// - Every new reading is also passed to fan speed control.
// - Reading bits 9..2 sit in the high byte and bits 1..0 in low byte bits 7..6.
// - The code spans -55 to +125 degrees at 0.25 degree per step.
`default_nettype none

module tzr_readout_regs #(
	parameter int TEMP_W = tzr_pkg::TEMP_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Byte register access from the serial interface engine
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Remote diode conversions
	input  wire logic              remote_meas_valid,
	input  wire logic [TEMP_W-1:0] remote_meas_temp,
	input  wire logic              remote_diode_fault,
	// On-die sensor conversions
	input  wire logic              local_meas_valid,
	input  wire logic [TEMP_W-1:0] local_meas_temp,
	// Fan control feed
	output logic                   fan_remote_valid,
	output logic      [TEMP_W-1:0] fan_remote_temp,
	output logic                   fan_local_valid,
	output logic      [TEMP_W-1:0] fan_local_temp,
	// Configuration to the rest of the device
	output logic                   measurement_stop,
	output logic                   alert_pin_select,
	output logic                   alert_mask,
	output logic      [7:0]        measurement_rate,
	output logic                   regs_locked,
	output logic      [7:0]        cooling_regs [tzr_pkg::LOCK_N]
);

	localparam logic [7:0] LOCK_BIT = 8'(1) << tzr_pkg::BIT_LOCK;

	// Storage
	logic [7:0]        device_configuration;
	logic [7:0]        lock_control;
	logic [7:0]        cooling_q [tzr_pkg::LOCK_N];
	logic [7:0]        low_thr   [tzr_pkg::ZONES];
	logic [7:0]        high_thr  [tzr_pkg::ZONES];
	logic [1:0]        low_snap  [tzr_pkg::ZONES];
	logic [TEMP_W-1:0] reading   [tzr_pkg::ZONES];
	logic              limit_evt [tzr_pkg::ZONES];
	logic              fault_evt [tzr_pkg::ZONES];
	logic              fan_valid [tzr_pkg::ZONES];
	logic [TEMP_W-1:0] fan_temp  [tzr_pkg::ZONES];
	logic              remote_zone_limit_flag;
	logic              local_zone_limit_flag;
	logic              remote_diode_fault_flag;

	// Measurement inputs gathered per zone
	// remote diode is zone zero
	wire logic              meas_valid [tzr_pkg::ZONES];
	wire logic [TEMP_W-1:0] meas_temp  [tzr_pkg::ZONES];
	wire logic              meas_fault [tzr_pkg::ZONES];
	assign meas_valid[tzr_pkg::ZONE_REMOTE] = remote_meas_valid;
	assign meas_temp[tzr_pkg::ZONE_REMOTE]  = remote_meas_temp;
	assign meas_fault[tzr_pkg::ZONE_REMOTE] = remote_diode_fault;
	assign meas_valid[tzr_pkg::ZONE_LOCAL]  = local_meas_valid;
	assign meas_temp[tzr_pkg::ZONE_LOCAL]   = local_meas_temp;
	assign meas_fault[tzr_pkg::ZONE_LOCAL]  = 1'b0; // On-die sensor has no open fault

	// Fixed register decode
	wire logic hit_config = reg_addr == tzr_pkg::OFF_CONFIG;
	wire logic hit_rate   = reg_addr == tzr_pkg::OFF_RATE;
	wire logic hit_ctrl   = reg_addr == tzr_pkg::OFF_CTRL;
	wire logic hit_flags1 = reg_addr == tzr_pkg::OFF_FLAGS1;
	wire logic hit_flags2 = reg_addr == tzr_pkg::OFF_FLAGS2;
	wire logic rd_flags1  = reg_rd & hit_flags1;
	wire logic rd_flags2  = reg_rd & hit_flags2;

	// Read-or chains for the per-entry registers
	wire logic [7:0] zone_rd [tzr_pkg::ZONES+1];
	wire logic [7:0] lock_rd [tzr_pkg::LOCK_N+1];
	assign zone_rd[0] = 8'h00;
	assign lock_rd[0] = 8'h00;

	// Per-zone reading, limits and byte split
	genvar z;
	generate
		for (z = 0; z < tzr_pkg::ZONES; z++) begin : g_zone
			wire logic hit_high   = reg_addr == tzr_pkg::ZONE_HIGH_OFF[z];
			wire logic hit_low    = reg_addr == tzr_pkg::ZONE_LOW_OFF[z];
			wire logic hit_lowthr = reg_addr == tzr_pkg::ZONE_LOWTHR_OFF[z];
			wire logic hit_hithr  = reg_addr == tzr_pkg::ZONE_HIGHTHR_OFF[z];
			wire logic [7:0] high_byte = reading[z][TEMP_W-1 -: 8];
			wire logic [7:0] low_byte  = {low_snap[z], 6'h00};
			wire logic [7:0] own_rd =
				hit_high   ? high_byte   :
				hit_low    ? low_byte    :
				hit_lowthr ? low_thr[z]  :
				hit_hithr  ? high_thr[z] : 8'h00;
			assign zone_rd[z+1] = zone_rd[z] | own_rd;

			tzr_zone #(
				.TEMP_W (TEMP_W)
			) u_zone (
				.clk        (clk),
				.rst        (rst),
				.meas_valid (meas_valid[z]),
				.meas_temp  (meas_temp[z]),
				.meas_fault (meas_fault[z]),
				.low_thr    (low_thr[z]),
				.high_thr   (high_thr[z]),
				.reading    (reading[z]),
				.limit_evt  (limit_evt[z]),
				.fault_evt  (fault_evt[z]),
				.fan_valid  (fan_valid[z]),
				.fan_temp   (fan_temp[z])
			);

			// Limits are never locked
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					low_thr[z]  <= tzr_pkg::RST_LOWTHR;
					high_thr[z] <= tzr_pkg::RST_HIGHTHR;
				end else if (reg_wr) begin
					if (hit_lowthr)
						low_thr[z] <= reg_wdata;
					if (hit_hithr)
						high_thr[z] <= reg_wdata;
				end
			end

			// Reading the high byte freezes the low bits of the same conversion
			// paired byte snapshot
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					low_snap[z] <= 2'b00;
				else if (reg_rd && hit_high)
					low_snap[z] <= reading[z][1:0];
			end
		end
	endgenerate

	// Lockable cooling registers, one entry each
	genvar k;
	generate
		for (k = 0; k < tzr_pkg::LOCK_N; k++) begin : g_lock
			wire logic hit = reg_addr == tzr_pkg::LOCK_OFF[k];
			wire logic we  = reg_wr & hit & ~regs_locked;
			wire logic [7:0] shown = cooling_q[k] & tzr_pkg::LOCK_MASK[k];
			assign lock_rd[k+1]   = lock_rd[k] | (hit ? shown : 8'h00);
			assign cooling_regs[k] = shown;

			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					cooling_q[k] <= tzr_pkg::LOCK_RST[k];
				else if (we)
					cooling_q[k] <= reg_wdata;
			end
		end
	endgenerate

	// Configuration, rate and lock control
	// Lock bit can only be set; only a reset releases it
	// sticky lock bit
	wire logic [7:0] next_ctrl = (reg_wdata & tzr_pkg::MASK_CTRL) | (lock_control & LOCK_BIT);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			device_configuration <= tzr_pkg::RST_CONFIG;
			measurement_rate     <= tzr_pkg::RST_RATE;
			lock_control         <= tzr_pkg::RST_CTRL;
		end else if (reg_wr) begin
			if (hit_config)
				device_configuration <= reg_wdata & tzr_pkg::MASK_CONFIG;
			if (hit_rate)
				measurement_rate <= reg_wdata;
			if (hit_ctrl)
				lock_control <= next_ctrl;
		end
	end

	assign regs_locked      = lock_control[tzr_pkg::BIT_LOCK];
	assign measurement_stop = device_configuration[tzr_pkg::BIT_RUN_STOP];
	assign alert_pin_select = device_configuration[tzr_pkg::BIT_ALERT_TACH];
	assign alert_mask       = device_configuration[tzr_pkg::BIT_ALERT_MASK];

	// Event flags: set by a conversion, cleared by reading them
	// A set in the clearing cycle wins, so no event is lost
	// fault sets both flags
	wire logic next_remote_limit =
		limit_evt[tzr_pkg::ZONE_REMOTE] | (remote_zone_limit_flag & ~rd_flags1);
	wire logic next_local_limit =
		limit_evt[tzr_pkg::ZONE_LOCAL] | (local_zone_limit_flag & ~rd_flags1);
	wire logic next_diode_fault =
		fault_evt[tzr_pkg::ZONE_REMOTE] | (remote_diode_fault_flag & ~rd_flags2);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remote_zone_limit_flag  <= 1'b0;
			local_zone_limit_flag   <= 1'b0;
			remote_diode_fault_flag <= 1'b0;
		end else begin
			remote_zone_limit_flag  <= next_remote_limit;
			local_zone_limit_flag   <= next_local_limit;
			remote_diode_fault_flag <= next_diode_fault;
		end
	end

	// Status bytes; everything outside the named flags reads zero
	// reserved status bits
	wire logic [7:0] flags1_raw = (8'(remote_zone_limit_flag) << tzr_pkg::BIT_REMOTE_LIMIT)
		| (8'(local_zone_limit_flag) << tzr_pkg::BIT_LOCAL_LIMIT);
	wire logic [7:0] flags2_raw = 8'(remote_diode_fault_flag) << tzr_pkg::BIT_DIODE_FAULT;
	wire logic [7:0] event_flags_first  = flags1_raw & tzr_pkg::MASK_FLAGS1;
	wire logic [7:0] event_flags_second = flags2_raw & tzr_pkg::MASK_FLAGS2;

	// Read selection; unmapped offsets fall through to 00h
	wire logic [7:0] rd_mux =
		hit_config ? device_configuration & tzr_pkg::MASK_CONFIG :
		hit_rate   ? measurement_rate                            :
		hit_ctrl   ? lock_control & tzr_pkg::MASK_CTRL           :
		hit_flags1 ? event_flags_first                           :
		hit_flags2 ? event_flags_second                          :
		zone_rd[tzr_pkg::ZONES] | lock_rd[tzr_pkg::LOCK_N];

	// Registered read data holds until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// Fan feed straight from the zone flops
	// fan feed ports
	assign fan_remote_valid = fan_valid[tzr_pkg::ZONE_REMOTE];
	assign fan_remote_temp  = fan_temp[tzr_pkg::ZONE_REMOTE];
	assign fan_local_valid  = fan_valid[tzr_pkg::ZONE_LOCAL];
	assign fan_local_temp   = fan_temp[tzr_pkg::ZONE_LOCAL];

	// quarter-degree code, +25 reads 19h / 00h
	wire logic [7:0] remote_high_byte = reading[tzr_pkg::ZONE_REMOTE][TEMP_W-1 -: 8];
	wire logic [7:0] local_high_byte  = reading[tzr_pkg::ZONE_LOCAL][TEMP_W-1 -: 8];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_reserved_zero: assert property (reg_rd && (hit_flags1 || hit_flags2) |=>
		(reg_rdata & ~(tzr_pkg::MASK_FLAGS1 | tzr_pkg::MASK_FLAGS2)) == 8'h00)
		else $error("reserved status bit read nonzero");
	a_fault_flags: assert property (remote_meas_valid && remote_diode_fault |=> ##1
		remote_zone_limit_flag && remote_diode_fault_flag)
		else $error("fault code did not set both flags");
	a_remote_zone_map: assert property (remote_meas_valid && !remote_diode_fault |=>
		reading[tzr_pkg::ZONE_REMOTE] == $past(remote_meas_temp))
		else $error("remote reading not taken from diode input");
	a_local_zone_map: assert property (local_meas_valid |=>
		reading[tzr_pkg::ZONE_LOCAL] == $past(local_meas_temp))
		else $error("local reading not taken from on-die input");
	a_high_byte_split: assert property (reg_rd && reg_addr == tzr_pkg::ZONE_HIGH_OFF[0] |=>
		reg_rdata == $past(remote_high_byte))
		else $error("high byte does not hold reading bits 9..2");
	a_byte_pairing: assert property (reg_rd && reg_addr == tzr_pkg::ZONE_HIGH_OFF[1]
		##1 reg_rd && reg_addr == tzr_pkg::ZONE_LOW_OFF[1] |=>
		reg_rdata[7:6] == $past(reading[tzr_pkg::ZONE_LOCAL][1:0], 2))
		else $error("low byte from another conversion");
	a_lock_hold: assert property (regs_locked && reg_wr |=>
		$stable(cooling_q[tzr_pkg::IDX_DUTY_FLOOR]) && regs_locked)
		else $error("locked register accepted a write");
	a_limit_flag: assert property (limit_evt[tzr_pkg::ZONE_LOCAL] |=>
		local_zone_limit_flag)
		else $error("local alarm flag not set");
	a_read_only: assert property (reg_wr && reg_addr == tzr_pkg::ZONE_HIGH_OFF[0]
		&& !remote_meas_valid |=> $stable(remote_high_byte))
		else $error("write altered remote reading");
	a_fan_remote: assert property (remote_meas_valid |=> fan_remote_valid)
		else $error("remote reading not forwarded");
	a_plus25_code: assert property (local_meas_valid && local_meas_temp == 10'h064 |=>
		local_high_byte == 8'h19)
		else $error("+25 degrees encoded wrongly");

	c_diode_fault: cover property (remote_meas_valid && remote_diode_fault);
	c_locked_write: cover property (regs_locked && reg_wr &&
		reg_addr == tzr_pkg::LOCK_OFF[tzr_pkg::IDX_DUTY_FLOOR]);
	c_pair_read: cover property (reg_rd && reg_addr == tzr_pkg::ZONE_HIGH_OFF[0]
		##1 reg_rd && reg_addr == tzr_pkg::ZONE_LOW_OFF[0]);
	c_set_on_clear: cover property (rd_flags1 && limit_evt[tzr_pkg::ZONE_REMOTE]);

endmodule

`default_nettype wire

// ---- hdl/tzr_pkg.sv ----
// Purpose: Shared constants for the zone temperature readout register block
// Assumes: Byte-wide register map reached through the serial interface engine
// Notes:   Offsets, reset values and read masks live here only
`default_nettype none

package tzr_pkg;

	// Reading format
	localparam int              TEMP_W        = 10;
	localparam int              ZONES         = 2;
	localparam int              ZONE_REMOTE   = 0;
	localparam int              ZONE_LOCAL    = 1;
	localparam logic [9:0]      FAULT_READING = 10'h200; // Reads as 80h / 00h

	// Register offsets
	localparam logic [7:0]      OFF_CONFIG = 8'h09;
	localparam logic [7:0]      OFF_RATE   = 8'h0A;
	localparam logic [7:0]      OFF_CTRL   = 8'h40;
	localparam logic [7:0]      OFF_FLAGS1 = 8'h41;
	localparam logic [7:0]      OFF_FLAGS2 = 8'h42;
	localparam logic [7:0]      ZONE_LOW_OFF    [ZONES] = '{8'h10, 8'h15};
	localparam logic [7:0]      ZONE_HIGH_OFF   [ZONES] = '{8'h25, 8'h26};
	localparam logic [7:0]      ZONE_LOWTHR_OFF [ZONES] = '{8'h4E, 8'h50};
	localparam logic [7:0]      ZONE_HIGHTHR_OFF[ZONES] = '{8'h4F, 8'h51};

	// Values after reset
	localparam logic [7:0]      RST_CONFIG  = 8'h00;
	localparam logic [7:0]      RST_RATE    = 8'h08;
	localparam logic [7:0]      RST_CTRL    = 8'h00;
	localparam logic [7:0]      RST_LOWTHR  = 8'h81;
	localparam logic [7:0]      RST_HIGHTHR = 8'h7F;
	localparam logic [9:0]      RST_READING = 10'h000;

	// Readable bits; everything else reads zero
	localparam logic [7:0]      MASK_CONFIG = 8'hE0;
	localparam logic [7:0]      MASK_CTRL   = 8'h0F;
	localparam logic [7:0]      MASK_FLAGS1 = 8'h30;
	localparam logic [7:0]      MASK_FLAGS2 = 8'h40;

	// Field positions
	localparam int              BIT_ALERT_MASK   = 7;
	localparam int              BIT_RUN_STOP     = 6;
	localparam int              BIT_ALERT_TACH   = 5;
	localparam int              BIT_LOCK         = 1;
	localparam int              BIT_REMOTE_LIMIT = 4;
	localparam int              BIT_LOCAL_LIMIT  = 5;
	localparam int              BIT_DIODE_FAULT  = 6;

	// Lockable cooling registers: offset, reset value, readable bits
	localparam int              LOCK_N = 14;
	localparam logic [7:0]      LOCK_OFF [LOCK_N] = '{
		8'h54, 8'h55, 8'h5C, 8'h5F, 8'h60, 8'h62, 8'h63,
		8'h64, 8'h67, 8'h68, 8'h6A, 8'h6B, 8'h6D, 8'h75};
	localparam logic [7:0]      LOCK_RST [LOCK_N] = '{
		8'hFF, 8'hFF, 8'h62, 8'hC3, 8'hC3, 8'h00, 8'h00,
		8'h80, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h44, 8'h07};
	localparam logic [7:0]      LOCK_MASK[LOCK_N] = '{
		8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hF0, 8'h2F, 8'hF0,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01};
	localparam int              IDX_DUTY_FLOOR = 7;

endpackage

`default_nettype wire

// ---- hdl/tzr_zone.sv ----
// Purpose: One temperature zone: latch reading, check limits, feed fan control
// Assumes: meas_valid is a one-cycle pulse per finished conversion
// Notes:   Limits compare against the whole-degree part of the reading
`default_nettype none

module tzr_zone #(
	parameter int TEMP_W = tzr_pkg::TEMP_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// New measurement
	input  wire logic              meas_valid,
	input  wire logic [TEMP_W-1:0] meas_temp,
	input  wire logic              meas_fault,
	// Programmed limits, signed whole degrees
	input  wire logic [7:0]        low_thr,
	input  wire logic [7:0]        high_thr,
	// Reading and events
	output logic      [TEMP_W-1:0] reading,
	output logic                   limit_evt,
	output logic                   fault_evt,
	// Fan control feed
	output logic                   fan_valid,
	output logic      [TEMP_W-1:0] fan_temp
);

	// Fault replaces the sample with the fault code
	// fault code substitute
	wire logic [TEMP_W-1:0] next_reading = meas_fault ? tzr_pkg::FAULT_READING : meas_temp;
	wire logic signed [7:0] whole        = next_reading[TEMP_W-1 -: 8];
	wire logic              above        = whole > $signed(high_thr);
	wire logic              below        = whole < $signed(low_thr);

	// Reading only moves on a conversion, so writes cannot touch it
	// read-only reading
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reading <= tzr_pkg::RST_READING;
		else if (meas_valid)
			reading <= next_reading;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			limit_evt <= 1'b0;
			fault_evt <= 1'b0;
		end else begin
			limit_evt <= meas_valid & (meas_fault | above | below);
			fault_evt <= meas_valid & meas_fault;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fan_valid <= 1'b0;
			fan_temp  <= tzr_pkg::RST_READING;
		end else begin
			fan_valid <= meas_valid;
			if (meas_valid)
				fan_temp <= next_reading;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_fault_code_load: assert property (meas_valid && meas_fault |=>
		reading == tzr_pkg::FAULT_READING && fault_evt && limit_evt)
		else $error("fault code not loaded");
	a_reading_hold: assert property (!meas_valid |=> $stable(reading))
		else $error("reading changed without a conversion");
	a_fan_forward: assert property (meas_valid |=> fan_valid && fan_temp == reading)
		else $error("fan feed missed a reading");
	a_limit_event: assert property (meas_valid && !meas_fault &&
		$signed(meas_temp[TEMP_W-1 -: 8]) > $signed(high_thr) |=> limit_evt)
		else $error("over-limit not flagged");

endmodule

`default_nettype wire

// ---- dv/tzr_sensor_model.sv ----
// Purpose: Conversion source for both zones, driven on request by the bench
// Assumes: One request at a time; the bench waits for its fan pulse
// Notes:   Between pulses the data lines toggle so stale values never match
`default_nettype none

module tzr_sensor_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Request from the bench
	input  wire logic       req,
	input  wire logic       req_local,
	input  wire logic [9:0] req_temp,
	input  wire logic       req_fault,
	input  wire logic [3:0] req_delay,
	// Conversion outputs
	output logic            remote_meas_valid,
	output logic      [9:0] remote_meas_temp,
	output logic            remote_diode_fault,
	output logic            local_meas_valid,
	output logic      [9:0] local_meas_temp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       pend;
	logic [3:0] wait_cnt;

	// Delay a request, then pulse one conversion; garbage outside the pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend               <= 1'b0;
			wait_cnt           <= 4'h0;
			remote_meas_valid  <= 1'b0;
			local_meas_valid   <= 1'b0;
			remote_meas_temp   <= 10'h000;
			local_meas_temp    <= 10'h000;
			remote_diode_fault <= 1'b0;
		end else begin
			remote_meas_valid  <= 1'b0;
			local_meas_valid   <= 1'b0;
			remote_meas_temp   <= ~remote_meas_temp;
			local_meas_temp    <= ~local_meas_temp;
			remote_diode_fault <= ~remote_diode_fault;
			if (req) begin
				pend     <= 1'b1;
				wait_cnt <= req_delay;
			end else if (pend && wait_cnt != 4'h0) begin
				wait_cnt <= wait_cnt - 4'h1;
			end else if (pend && req_local) begin
				pend             <= 1'b0;
				local_meas_valid <= 1'b1;
				local_meas_temp  <= req_temp;
			end else if (pend) begin
				pend               <= 1'b0;
				remote_meas_valid  <= 1'b1;
				remote_meas_temp   <= req_temp;
				remote_diode_fault <= req_fault;
			end
		end
	end
endmodule

`default_nettype wire

// ---- dv/test_tzr_readout_regs.sv ----
// Purpose: Self-checking bench for the zone readout register block
// Assumes: Sensor model supplies conversions on request
// Notes:   Seed fixed at 67 so every run repeats
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module test_tzr_readout_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic       req = 0, req_local = 0, req_fault = 0, loc, flt;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val, rd_hi;
	logic [7:0] lo_thr = 8'h81, hi_thr = 8'h7F, measurement_rate;
	logic [9:0] req_temp = 10'h000, tmp, remote_meas_temp, local_meas_temp;
	logic [9:0] fan_remote_temp, fan_local_temp;
	logic [3:0] req_delay = 4'h0;
	logic       remote_meas_valid, remote_diode_fault, local_meas_valid;
	logic       fan_remote_valid, fan_local_valid, measurement_stop;
	logic       alert_pin_select, alert_mask, regs_locked;
	logic [7:0] cooling_regs [tzr_pkg::LOCK_N];
	int         num_errors = 0, check_count = 0, seed = 67;
	localparam logic [7:0] RA [13] = '{8'h09, 8'h0A, 8'h10, 8'h15, 8'h25, 8'h26, 8'h41,
		8'h42, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h03};
	localparam logic [7:0] RV [13] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h81, 8'h7F, 8'h81, 8'h7F, 8'h00};
	localparam logic [9:0] CT [6] = '{10'h064, 10'h324, 10'h1F4, 10'h007, 10'h3F9, 10'h064};
	localparam logic [7:0] CH [6] = '{8'h19, 8'hC9, 8'h7D, 8'h01, 8'hFE, 8'h19};

	tzr_readout_regs tzr_readout_regs_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.remote_meas_valid(remote_meas_valid), .remote_meas_temp(remote_meas_temp),
		.remote_diode_fault(remote_diode_fault), .local_meas_valid(local_meas_valid),
		.local_meas_temp(local_meas_temp), .fan_remote_valid(fan_remote_valid),
		.fan_remote_temp(fan_remote_temp), .fan_local_valid(fan_local_valid),
		.fan_local_temp(fan_local_temp), .measurement_stop(measurement_stop),
		.alert_pin_select(alert_pin_select), .alert_mask(alert_mask),
		.measurement_rate(measurement_rate), .regs_locked(regs_locked),
		.cooling_regs(cooling_regs));
	tzr_sensor_model tzr_sensor_model_inst (.clk(clk), .rst(rst), .req(req),
		.req_local(req_local), .req_temp(req_temp), .req_fault(req_fault),
		.req_delay(req_delay), .remote_meas_valid(remote_meas_valid),
		.remote_meas_temp(remote_meas_temp), .remote_diode_fault(remote_diode_fault),
		.local_meas_valid(local_meas_valid), .local_meas_temp(local_meas_temp));

	// 50 MHz clock
	always #10 clk = ~clk;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data is sampled just after the taking edge has registered it
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	// High byte then low byte back to back, as a host reads one reading
	task automatic rd2(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_addr <= b;
		#1 rd_hi = reg_rdata;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	// Expected alarm: whole degrees outside the limits, or a diode fault
	function automatic logic lim(input logic [9:0] t, input logic f);
		return f || $signed(t[9:2]) > $signed(hi_thr) || $signed(t[9:2]) < $signed(lo_thr);
	endfunction

	task automatic meas(input logic l, input logic [9:0] t, input logic f);
		logic [9:0] e;
		logic       a;
		int         n;
		e = f ? 10'h200 : t;
		a = lim(t, f);
		@(posedge clk);
		req       <= 1'b1;
		req_local <= l;
		req_temp  <= t;
		req_fault <= f;
		req_delay <= 4'($random(seed));
		@(posedge clk);
		req <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			#1;
			if ((l ? fan_local_valid : fan_remote_valid) === 1'b1) break;
		end
		`CHK(n < 40, 1'b1)
		`CHK(l ? fan_local_temp : fan_remote_temp, e)
		rd2(l ? 8'h26 : 8'h25, l ? 8'h15 : 8'h10);
		`CHK(rd_hi, e[9:2])
		`CHK(rd_val & 8'hC0, {e[1:0], 6'h00})
		rd(8'h41);
		`CHK(rd_val, {2'b00, l & a, !l & a, 4'h0})
		rd(8'h42);
		`CHK(rd_val, {1'b0, f, 6'h00})
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, far beyond the expected run length
	initial begin
		#200000; // 10,000 cycles, several times the full run
		num_errors++;
		summarize();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (RA[i]) begin
			rd(RA[i]);
			`CHK(rd_val, RV[i])
		end
		for (int i = 0; i < tzr_pkg::LOCK_N; i++) begin
			rd(tzr_pkg::LOCK_OFF[i]);
			`CHK(rd_val, tzr_pkg::LOCK_RST[i] & tzr_pkg::LOCK_MASK[i])
			`CHK(cooling_regs[i], tzr_pkg::LOCK_RST[i] & tzr_pkg::LOCK_MASK[i])
		end
		wr(8'h09, 8'hFF);
		rd(8'h09);
		`CHK(rd_val, 8'hE0)
		`CHK({alert_mask, measurement_stop, alert_pin_select}, 3'h7)
		wr(8'h0A, 8'h5A);
		#1; // Let the write edge settle first
		`CHK(measurement_rate, 8'h5A)
		foreach (CT[i]) begin
			meas(1'(i & 1), CT[i], 1'b0);
			rd((i & 1) ? 8'h26 : 8'h25);
			`CHK(rd_val, CH[i])
		end
		wr(8'h25, 8'hFF);
		wr(8'h10, 8'hFF);
		// Last remote conversion was CT[4]
		rd(8'h25);
		`CHK(rd_val, CT[4][9:2])
		rd(8'h10);
		`CHK(rd_val, {CT[4][1:0], 6'h00})
		// Random conversions, faults and limits
		for (int i = 0; i < 30; i++) begin
			if (i % 6 == 0) begin
				lo_thr = 8'($random(seed));
				hi_thr = 8'($random(seed));
				wr(8'h4E, lo_thr);
				wr(8'h4F, hi_thr);
				wr(8'h50, lo_thr);
				wr(8'h51, hi_thr);
			end
			// Pass 3 forces a diode fault, which only the remote zone has
			loc = (i == 3) ? 1'b0 : 1'($random(seed));
			flt = !loc && ((($random(seed) & 7) == 0) || i == 3);
			tmp = 10'($random(seed));
			meas(loc, tmp, flt);
		end
		// lock stops cooling writes until reset
		wr(8'h64, 8'h33);
		wr(8'h40, 8'h02);
		wr(8'h64, 8'hCC);
		rd(8'h64);
		`CHK(rd_val, 8'h33)
		`CHK({regs_locked, cooling_regs[tzr_pkg::IDX_DUTY_FLOOR]}, 9'h133)
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wr(8'h64, 8'h44);
		rd(8'h64);
		`CHK({regs_locked, rd_val}, 9'h044)
		summarize();
	end
endmodule

`default_nettype wire
